// File: cteq_pkg.sv
package cteq_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] OFF_DONE_MASK = 8'he0;
    localparam logic [7:0] OFF_CANCEL_MASK = 8'he4;
    localparam logic [7:0] OFF_CONFIG = 8'hf0;
    localparam logic [7:0] OFF_STATUS = 8'hf4;
    localparam logic [7:0] OFF_ACK = 8'hf8;
    localparam logic [7:0] OFF_RX_CTRL = 8'hfc;
    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int CFG_WM_LSB = 24;
    localparam int CFG_DEPTH_LSB = 16;
    localparam int ST_LOST_BIT = 25;
    localparam int ST_FULL_BIT = 24;
    localparam int ST_WPTR_LSB = 16;
    localparam int ST_RPTR_LSB = 8;
    localparam int ST_LEVEL_LSB = 0;
    localparam int W1_UNMATCH_BIT = 31;
    localparam int W1_MATCHED_FILTER_NUMBER_LSB = 24;
    localparam int W1_FDF_BIT = 21;
    localparam int W1_BRS_BIT = 20;
    localparam int W1_DLC_LSB = 16;
    localparam int W1_TSC_BIT = 4;
    localparam int W0_ESI_BIT = 31;
    localparam int W0_XTD_BIT = 30;
    localparam int W0_RTR_BIT = 29;
    localparam int W0_STD_LSB = 18;
    // ****************************************************************
    // reset values and constants
    // ****************************************************************
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [5:0] MAX_DEPTH = 6'h20;
    localparam logic [1:0] EVT_TX = 2'h1;
    localparam logic [1:0] EVT_CANCELLED = 2'h2;
    localparam logic [31:0] BASE_MASK = 32'h0000_fffc;
    localparam int RAM_WORDS = 4352;
    localparam int RX_BUFFERS = 64;
    localparam int RX_QUEUE_DEPTH = 64;
endpackage

// File: cteq_event_queue.sv
`timescale 1ns/100ps
module cteq_event_queue
    import cteq_pkg::*;
#(
    parameter int NUM_BUFFERS = 32
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // transmit completion events
    input wire logic tx_done,
    input wire logic tx_cancel_done,
    input wire logic [4:0] tx_buffer,
    input wire logic log_tx_event_flag,
    input wire logic tx_cancel_requested,
    output logic done_irq,
    output logic cancel_irq,
    // event queue write into message RAM
    output logic ram_we,
    output logic [13:0] ram_addr,
    output logic [1:0] tx_event_type,
    // event queue interrupts, cleared by pulses
    input wire logic lost_irq_clear,
    input wire logic watermark_irq_clear,
    output logic event_queue_lost_irq,
    output logic event_queue_watermark_irq,
    // received frame element assembly
    input wire logic rx_esi,
    input wire logic extended_id_flag,
    input wire logic rx_rtr,
    input wire logic [28:0] rx_id,
    input wire logic unmatched_accept_flag,
    input wire logic [6:0] matched_filter_number,
    input wire logic rx_fdf,
    input wire logic rx_brs,
    input wire logic [3:0] rx_dlc,
    input wire logic [15:0] internal_stamp,
    input wire logic filter_sync_capture,
    input wire logic [3:0] receive_stamp_slot,
    output logic [31:0] rx_word0,
    output logic [31:0] rx_word1,
    output logic external_stamp_select
);
    // receive element capacity that the word layout below serves
    localparam int RX_ELEMENTS = RX_BUFFERS + 2 * RX_QUEUE_DEPTH;
    // word address reach of the 14-bit ram address
    localparam int ADDR_WORDS = 16384;

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // refuse sizes that the 5-bit buffer index and pointers cannot serve
    initial begin
        if (NUM_BUFFERS < 1 || NUM_BUFFERS > 32) begin
            $error("NUM_BUFFERS must be 1 to 32");
        end
        // configured sections must fit the word address reach
        if (RAM_WORDS > ADDR_WORDS) begin
            $error("message ram larger than address reach");
        end
        // two queues plus dedicated buffers share one element layout
        if (RX_ELEMENTS != 192) begin
            $error("receive element count unsupported");
        end
    end

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [31:0] done_mask;
        logic [31:0] cancel_mask;
        logic [5:0] wm;
        logic [5:0] depth;
        logic [13:0] base;
        logic [4:0] wptr;
        logic [4:0] rptr;
        logic [5:0] level;
        logic lost;
        logic wm_irq;
        logic [4:0] ack;
        logic ext_sel;
        logic [31:0] rdata;
        logic done_irq;
        logic cancel_irq;
        logic we;
        logic [13:0] addr;
        logic [1:0] etype;
        logic [31:0] w0;
        logic [31:0] w1;
    } cteq_state_s;

    cteq_state_s st;
    cteq_state_s next_st;
    logic wr;
    logic rd;
    logic [5:0] eff_depth;
    logic full;
    logic log_evt;
    logic store;
    logic [5:0] new_level;

    assign wr = psel && penable && pwrite;
    // read data captured in the setup cycle so it stands in the access
    // cycle, when the master takes it with pready high
    assign rd = psel && !penable && !pwrite;
    // effective depth, clipped to the maximum
    assign eff_depth = (st.depth > MAX_DEPTH) ? MAX_DEPTH : st.depth;
    assign full = (eff_depth != 6'h00) && (st.level >= eff_depth);
    assign log_evt = tx_done && log_tx_event_flag;
    assign store = log_evt && !full && (eff_depth != 6'h00);

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [4:0] np;
        logic [5:0] lvl;
        next_st = st;
        np = 5'h00;
        lvl = st.level;
        next_st.we = 1'b0;
        next_st.done_irq = 1'b0;
        next_st.cancel_irq = 1'b0;
        // per-buffer interrupt gating
        if (tx_done) begin
            next_st.done_irq = st.done_mask[tx_buffer];
        end
        if (tx_cancel_done) begin
            next_st.cancel_irq = st.cancel_mask[tx_buffer];
        end
        // register writes
        if (wr) begin
            unique case (paddr)
                OFF_DONE_MASK: next_st.done_mask = pwdata;
                OFF_CANCEL_MASK: next_st.cancel_mask = pwdata;
                OFF_CONFIG: begin
                    next_st.wm = pwdata[CFG_WM_LSB +: 6];
                    next_st.depth = pwdata[CFG_DEPTH_LSB +: 6];
                    next_st.base = pwdata[15:2];
                end
                OFF_ACK: begin
                    next_st.ack = pwdata[4:0];
                    np = pwdata[4:0] + 5'h01;
                    if (eff_depth != 6'h00 && {1'b0, np} >= eff_depth) begin
                        np = 5'h00;
                    end
                    next_st.rptr = np;
                    if (st.wptr > np) begin
                        lvl = {1'b0, st.wptr - np};
                    end else if (st.wptr < np || full) begin
                        lvl = 6'(eff_depth - {1'b0, np} + {1'b0, st.wptr});
                    end else begin
                        lvl = 6'h00;
                    end
                end
                OFF_RX_CTRL: next_st.ext_sel = pwdata[0];
                default: begin
                end
            endcase
        end
        // event storage into the queue
        if (store) begin
            next_st.we = 1'b1;
            next_st.addr = 14'(st.base + ({9'h000, st.wptr} << 1));
            next_st.etype = tx_cancel_requested ? EVT_CANCELLED
                                                : EVT_TX;
            if ({1'b0, st.wptr} + 6'h01 >= eff_depth) begin
                next_st.wptr = 5'h00;
            end else begin
                next_st.wptr = st.wptr + 5'h01;
            end
            lvl = lvl + 6'h01;
        end
        next_st.level = lvl;
        // watermark flag: set wins over clear
        if (store && st.wm != 6'h00 && st.wm <= MAX_DEPTH && lvl == st.wm) begin
            next_st.wm_irq = 1'b1;
        end else if (watermark_irq_clear) begin
            next_st.wm_irq = 1'b0;
        end
        // lost flag: set wins over clear
        if (log_evt && !store) begin
            next_st.lost = 1'b1;
        end else if (lost_irq_clear) begin
            next_st.lost = 1'b0;
        end
        // read data
        next_st.rdata = RST_WORD;
        if (rd) begin
            unique case (paddr)
                OFF_DONE_MASK: next_st.rdata = st.done_mask;
                OFF_CANCEL_MASK: next_st.rdata = st.cancel_mask;
                OFF_CONFIG: begin
                    next_st.rdata[CFG_WM_LSB +: 6] = st.wm;
                    next_st.rdata[CFG_DEPTH_LSB +: 6] = st.depth;
                    next_st.rdata[15:2] = st.base;
                end
                OFF_STATUS: begin
                    next_st.rdata[ST_LOST_BIT] = st.lost;
                    next_st.rdata[ST_FULL_BIT] = full;
                    next_st.rdata[ST_WPTR_LSB +: 5] = st.wptr;
                    next_st.rdata[ST_RPTR_LSB +: 5] = st.rptr;
                    next_st.rdata[ST_LEVEL_LSB +: 6] = st.level;
                end
                OFF_ACK: next_st.rdata[4:0] = st.ack;
                OFF_RX_CTRL: next_st.rdata[0] = st.ext_sel;
                default: begin
                end
            endcase
        end
        // received frame element words
        next_st.w0 = RST_WORD;
        next_st.w0[W0_ESI_BIT] = rx_esi;
        next_st.w0[W0_XTD_BIT] = extended_id_flag;
        next_st.w0[W0_RTR_BIT] = rx_rtr;
        next_st.w0[28:0] = extended_id_flag ? rx_id
                         : {rx_id[10:0], 18'h00000};
        next_st.w1 = RST_WORD;
        next_st.w1[W1_UNMATCH_BIT] = unmatched_accept_flag;
        next_st.w1[W1_MATCHED_FILTER_NUMBER_LSB +: 7] = matched_filter_number;
        next_st.w1[W1_FDF_BIT] = rx_fdf;
        next_st.w1[W1_BRS_BIT] = rx_brs;
        next_st.w1[W1_DLC_LSB +: 4] = rx_dlc;
        if (st.ext_sel) begin
            next_st.w1[W1_TSC_BIT] = filter_sync_capture;
            next_st.w1[3:0] = receive_stamp_slot;
        end else begin
            next_st.w1[15:0] = internal_stamp;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = st.rdata;
    assign done_irq = st.done_irq;
    assign cancel_irq = st.cancel_irq;
    assign ram_we = st.we;
    assign ram_addr = st.addr;
    assign tx_event_type = st.etype;
    assign event_queue_lost_irq = st.lost;
    assign event_queue_watermark_irq = st.wm_irq;
    assign rx_word0 = st.w0;
    assign rx_word1 = st.w1;
    assign external_stamp_select = st.ext_sel;

    // ****************************************************************
    // checks
    // ****************************************************************
    // queue pointers, level and flags
    a_full_discard: assert property (
        @(posedge pclk) disable iff (!presetn)
        (log_evt && full && !wr) |=> ($stable(st.wptr) && st.lost))
        else $error("event on full queue not discarded");
    a_level_bound: assert property (
        @(posedge pclk) disable iff (!presetn)
        st.level <= MAX_DEPTH)
        else $error("fill level above maximum");
    a_store_adv: assert property (
        @(posedge pclk) disable iff (!presetn)
        (store && !wr) |=> (st.level == $past(st.level) + 6'h01))
        else $error("level did not advance");
    a_no_log: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!log_tx_event_flag) |=> !st.we)
        else $error("event logged without store bit");
    a_zero_depth: assert property (
        @(posedge pclk) disable iff (!presetn)
        (log_evt && eff_depth == 6'h00) |=> st.lost)
        else $error("depth zero write not lost");
    a_ack_ptr: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == OFF_ACK && st.depth == MAX_DEPTH)
        |=> st.rptr == $past(pwdata[4:0]) + 5'h01)
        else $error("read pointer not ack plus one");
    a_wptr_wrap: assert property (
        @(posedge pclk) disable iff (!presetn)
        (store && 6'({1'b0, st.wptr} + 6'h01) == eff_depth)
        |=> st.wptr == 5'h00)
        else $error("write pointer did not wrap");
    a_lost_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        (lost_irq_clear && !log_evt) |=> !event_queue_lost_irq)
        else $error("lost flag not cleared");

    // watermark flag
    a_wm_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        (store && !wr && st.wm != 6'h00 && st.wm <= MAX_DEPTH
            && st.level + 6'h01 == st.wm) |=> event_queue_watermark_irq)
        else $error("watermark flag not raised");
    a_wm_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st.wm == 6'h00 || st.wm > MAX_DEPTH) |=> !$rose(st.wm_irq))
        else $error("disabled watermark raised flag");

    // interrupt masks
    a_done_gate: assert property (
        @(posedge pclk) disable iff (!presetn)
        (tx_done && !st.done_mask[tx_buffer]) |=> !done_irq)
        else $error("masked done interrupt raised");
    a_cancel_gate: assert property (
        @(posedge pclk) disable iff (!presetn)
        (tx_cancel_done && st.cancel_mask[tx_buffer]) |=> cancel_irq)
        else $error("cancel interrupt missing");

    // received element words
    a_std_id: assert property (
        @(posedge pclk) disable iff (!presetn)
        !extended_id_flag |=> rx_word0[17:0] == 18'h00000)
        else $error("standard identifier misplaced");
    a_int_stamp: assert property (
        @(posedge pclk) disable iff (!presetn)
        !external_stamp_select |=> rx_word1[15:0] == $past(internal_stamp))
        else $error("internal stamp not stored");
endmodule

// File: cteq_ram_model.sv
`timescale 1ns/100ps
// ****************************************************************
// message ram model, event queue side
// ****************************************************************
module cteq_ram_model (
    // clock
    input wire logic pclk,
    // event element write port
    input wire logic ram_we,
    input wire logic [13:0] ram_addr,
    input wire logic [1:0] tx_event_type,
    // write counter for the bench
    output logic [7:0] wr_count
);
    // word addressed store, one entry per 32-bit word
    logic [1:0] mem [0:16383];
    initial wr_count = 8'h00;
    // every word cleared at time zero, as parity ram would need
    initial begin
        for (int i = 0; i < 16384; i++) begin
            mem[i] = 2'h0;
        end
    end
    // capture each queued event type at its word address
    always @(posedge pclk) begin
        if (ram_we === 1'b1) begin
            mem[ram_addr] <= tx_event_type;
            wr_count <= wr_count + 8'h01;
        end
    end
endmodule

// File: tb_top.sv
`timescale 1ns/100ps
// ****************************************************************
// bench top
// ****************************************************************
module tb_top;
    import cteq_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, wr_count;
    logic [31:0] pwdata, prdata, rx_word0, rx_word1, rd;
    logic tx_done, tx_cancel_done, log_tx_event_flag, tx_cancel_requested;
    logic [4:0] tx_buffer;
    logic done_irq, cancel_irq, ram_we, lost_irq_clear, watermark_irq_clear;
    logic [13:0] ram_addr;
    logic [1:0] tx_event_type;
    logic event_queue_lost_irq, event_queue_watermark_irq;
    logic rx_esi, extended_id_flag, rx_rtr, unmatched_accept_flag;
    logic rx_fdf, rx_brs, filter_sync_capture, external_stamp_select;
    logic [28:0] rx_id;
    logic [6:0] matched_filter_number;
    logic [3:0] rx_dlc, receive_stamp_slot;
    logic [15:0] internal_stamp;
    int errors = 0;
    int checks_done = 0;
    cteq_event_queue i_cteq_event_queue (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_done,
        .tx_cancel_done, .tx_buffer, .log_tx_event_flag,
        .tx_cancel_requested, .done_irq, .cancel_irq, .ram_we, .ram_addr,
        .tx_event_type, .lost_irq_clear, .watermark_irq_clear,
        .event_queue_lost_irq, .event_queue_watermark_irq, .rx_esi,
        .extended_id_flag, .rx_rtr, .rx_id, .unmatched_accept_flag,
        .matched_filter_number, .rx_fdf, .rx_brs, .rx_dlc, .internal_stamp,
        .filter_sync_capture, .receive_stamp_slot, .rx_word0, .rx_word1,
        .external_stamp_select);
    cteq_ram_model i_cteq_ram_model (.pclk, .ram_we, .ram_addr,
        .tx_event_type, .wr_count);
    // 10 MHz clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic tally_and_finish();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("Error t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one apb transfer, read data taken at the access edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        if (n >= 20) begin
            errors++;
            tally_and_finish();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] st(input logic l, input logic f,
        input logic [4:0] w, input logic [4:0] r, input logic [5:0] n);
        return {6'h0, l, f, 3'h0, w, 3'h0, r, 2'h0, n};
    endfunction
    // one completion event, outputs judged the cycle after
    task automatic ev(input logic lg, input logic cr, input logic [4:0] b,
        input logic we, input logic [13:0] a, input logic irq);
        @(posedge pclk);
        tx_done <= 1'b1;
        log_tx_event_flag <= lg;
        tx_cancel_requested <= cr;
        tx_buffer <= b;
        @(posedge pclk);
        tx_done <= 1'b0;
        #1 chk(ram_we, we);
        chk(done_irq, irq);
        if (we) begin
            chk(ram_addr, a);
            chk(tx_event_type, cr ? EVT_CANCELLED : EVT_TX);
        end
    endtask
    task automatic masks_and_cancel();
        apb(1'b1, OFF_DONE_MASK, 32'h0000_0004);
        apb(1'b1, OFF_CANCEL_MASK, 32'h8000_0001);
        apb(1'b0, OFF_CANCEL_MASK, 32'h0);
        chk(rd, 32'h8000_0001);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 2; i++) begin
            @(posedge pclk);
            tx_cancel_done <= 1'b1;
            tx_buffer <= 5'(i);
            @(posedge pclk);
            tx_cancel_done <= 1'b0;
            #1 chk(cancel_irq, 32'(i == 0));
        end
    endtask
    task automatic queue_fill_ack();
        apb(1'b1, OFF_CONFIG, 32'h0202_0103);
        ev(1'b1, 1'b0, 5'h2, 1'b1, 14'h40, 1'b1);
        ev(1'b1, 1'b1, 5'h3, 1'b1, 14'h42, 1'b0);
        chk(event_queue_watermark_irq, 1);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd, st(1'b0, 1'b1, 5'h0, 5'h0, 6'h2));
        ev(1'b1, 1'b0, 5'h1, 1'b0, 14'h0, 1'b0);
        chk(event_queue_lost_irq, 1);
        apb(1'b1, OFF_ACK, 32'h0);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd, st(1'b1, 1'b0, 5'h0, 5'h1, 6'h1));
        ev(1'b0, 1'b0, 5'h1, 1'b0, 14'h0, 1'b0);
        @(posedge pclk);
        lost_irq_clear <= 1'b1;
        @(posedge pclk);
        lost_irq_clear <= 1'b0;
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd[ST_LOST_BIT], 0);
        apb(1'b1, OFF_CONFIG, 32'h0000_0103);
        ev(1'b1, 1'b0, 5'h1, 1'b0, 14'h0, 1'b0);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd[ST_LOST_BIT], 1);
        chk(wr_count, 2);
        apb(1'b1, OFF_CONFIG, 32'h0020_0103);
        apb(1'b1, OFF_ACK, 32'h0000_0005);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd, st(1'b1, 1'b0, 5'h0, 5'h6, 6'h1a));
    endtask
    task automatic rx_words();
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, OFF_RX_CTRL, 32'(s));
            @(posedge pclk);
            {rx_esi, extended_id_flag, rx_rtr} <= 3'b101;
            rx_id <= 29'h0000_06af;
            {unmatched_accept_flag, matched_filter_number} <= 8'h7f;
            {rx_fdf, rx_brs, rx_dlc} <= 6'h2d;
            internal_stamp <= 16'hbeef;
            filter_sync_capture <= 1'b1;
            receive_stamp_slot <= 4'h9;
            repeat (2) @(posedge pclk);
            #1 chk(rx_word0, 32'hbabc_0000);
            chk(rx_word1, s ? 32'h7f2d_0019 : 32'h7f2d_beef);
        end
    endtask
    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {tx_done, tx_cancel_done, tx_buffer} = '0;
        {log_tx_event_flag, tx_cancel_requested} = '0;
        {lost_irq_clear, watermark_irq_clear} = '0;
        {rx_esi, extended_id_flag, rx_rtr, rx_id} = '0;
        {unmatched_accept_flag, matched_filter_number} = '0;
        {rx_fdf, rx_brs, rx_dlc, internal_stamp} = '0;
        {filter_sync_capture, receive_stamp_slot} = '0;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        masks_and_cancel();
        queue_fill_ack();
        rx_words();
        tally_and_finish();
    end
endmodule
